// ---- design/cbim_core.sv ----
// Purpose: executes skip, relative branch, move and load/store words
// Assumes: IW_I/IW_NEXT_I show program words at PC_O and PC_O+1 in the
//          same cycle; IO_RDATA_I shows the I/O register named by
//          IW_I[7:3]; DM_RDATA_I is valid while DM_RE_O is high
// Notes:   words of other classes retire in one cycle with PC+1
//
// Summary of operation
// - skip-if-io-bit-clear skips 1 or 2 words when bit is 0; 1/2/3 cycles
// - skip-if-io-bit-set skips 1 or 2 words when bit is 1; 1/2/3 cycles
// - status-bit-set branch jumps to PC+offset+1 when selected bit is 1
// - status-bit-clear branch jumps when bit is 0; 1 or 2 cycles
// - carry set/clear branches test the carry flag; 1 or 2 cycles
// - same-or-higher branches on carry 0, lower on carry 1
// - signed greater-or-equal branches when N xor V is 0
// - signed less-than branches when N xor V is 1; 1 or 2 cycles
// - half-carry branches test the half carry flag; 1 or 2 cycles
// - copy-bit branches test the T flag, relative target
// - overflow branches test the V flag; 1 or 2 cycles
// - interrupt-state branches test the I flag; 1 or 2 cycles
// - post-increment load reads at pointer, then pointer plus one; 2 cycles
// - pre-decrement load decrements pointer, then reads there; 2 cycles
// - displacement load reads Y or Z plus q, pointer kept; 2 cycles
// - direct load reads the absolute address in the second word; 2 cycles
// - post-increment store writes at pointer, then increments; 2 cycles
// - pre-decrement store decrements pointer, then writes; 2 cycles
// - displacement store writes at pointer plus q, pointer kept; 2 cycles
`timescale 1ns/1ps
`default_nettype none
module cbim_core (
  // clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  // program memory
  output logic      [15:0] PC_O,
  input  wire logic [15:0] IW_I,
  input  wire logic [15:0] IW_NEXT_I,
  // status and I/O inputs
  input  wire logic [7:0]  FLAGS_I,
  input  wire logic [7:0]  IO_RDATA_I,
  // data memory
  output logic      [15:0] DM_ADDR_O,
  output logic      [7:0]  DM_WDATA_O,
  output logic             DM_WE_O,
  output logic             DM_RE_O,
  input  wire logic [7:0]  DM_RDATA_I,
  // observation
  output logic             DONE_O,
  input  wire logic [4:0]  REG_SEL_I,
  output logic      [7:0]  REG_DATA_O
);
  import cbim_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  typedef enum logic [1:0] {S_EXEC, S_MEM, S_WAIT} cbim_state_t;

  cbim_state_t state_q, state_d;
  logic [15:0] pc_q, pc_d;
  logic [1:0]  wait_q, wait_d;
  logic [15:0] dm_addr_q, dm_addr_d;
  logic [7:0]  dm_wdata_q, dm_wdata_d;
  logic        dm_we_q, dm_we_d;
  logic        dm_re_q, dm_re_d;
  logic [4:0]  load_rd_q, load_rd_d;
  logic        done_q, done_d;
  logic [7:0]  dbg_q, dbg_d;

  logic [7:0]  rd_a;
  logic [7:0]  rd_b;
  logic [7:0]  rd_c;
  logic [15:0] ptr_val;
  logic [15:0] ptr_next;
  logic [15:0] mem_addr;
  logic [15:0] koff_ext;
  logic [4:0]  ra_addr;
  logic [4:0]  rb_addr;
  logic        flag;
  logic        taken;
  logic        io_bit;
  logic        wb_en;
  logic [4:0]  wb_addr;
  logic [7:0]  wb_data;
  logic        wp_en;
  logic [3:0]  wp_idx;
  logic [15:0] wp_data;

  cbim_dec_if dec ();

  // ****************************************************************
  // decoder and register file
  // ****************************************************************
  assign dec.iw = IW_I;

  cbim_decode u_decode (
    .d (dec)
  );

  // store data or move source on port a, odd pair half on port b
  assign ra_addr = (dec.cls == C_STORE) ? dec.rd : dec.rr;
  assign rb_addr = {dec.rr[4:1], 1'b1};

  cbim_regfile u_regfile (
    .clk_i     (CLK_I),
    .ra_addr_i (ra_addr),
    .ra_data_o (rd_a),
    .rb_addr_i (rb_addr),
    .rb_data_o (rd_b),
    .rc_addr_i (REG_SEL_I),
    .rc_data_o (rd_c),
    .rp_idx_i  (dec.pair),
    .rp_data_o (ptr_val),
    .wb_en_i   (wb_en),
    .wb_addr_i (wb_addr),
    .wb_data_i (wb_data),
    .wp_en_i   (wp_en),
    .wp_idx_i  (wp_idx),
    .wp_data_i (wp_data)
  );

  // ****************************************************************
  // condition evaluation for skips and branches
  // ****************************************************************
  assign io_bit   = IO_RDATA_I[dec.sbit];
  assign koff_ext = {{9{dec.koff[6]}}, dec.koff};

  // selected status condition; aliases share the bit field
  always_comb begin
    flag = 1'b0;
    unique case (dec.sbit)
      FLAG_C: flag = FLAGS_I[FLAG_C];
      FLAG_Z: flag = FLAGS_I[FLAG_Z];
      FLAG_N: flag = FLAGS_I[FLAG_N];
      FLAG_V: flag = FLAGS_I[FLAG_V];
      FLAG_S: flag = FLAGS_I[FLAG_N] ^ FLAGS_I[FLAG_V];
      FLAG_H: flag = FLAGS_I[FLAG_H];
      FLAG_T: flag = FLAGS_I[FLAG_T];
      FLAG_I: flag = FLAGS_I[FLAG_I];
    endcase
  end

  // set variant takes on 1, clear variant on 0
  assign taken = flag ^ dec.pol;

  // ****************************************************************
  // address generation for loads and stores
  // ****************************************************************
  always_comb begin
    mem_addr = ptr_val;
    unique case (dec.amode)
      A_PLAIN: mem_addr = ptr_val;
      A_INC: mem_addr = ptr_val;
      A_DEC: mem_addr = ptr_val - PC_STEP;
      A_DISP: mem_addr = ptr_val + {10'h000, dec.disp};
      A_DIRECT: mem_addr = IW_NEXT_I;
      default: mem_addr = ptr_val;                  // unused codes
    endcase
  end

  // pointer write-back value: step down or up by one
  assign ptr_next = (dec.amode == A_DEC) ? (ptr_val - PC_STEP)
                                         : (ptr_val + PC_STEP);

  // ****************************************************************
  // execution sequencer: next values
  // ****************************************************************
  always_comb begin
    state_d    = state_q;
    pc_d       = pc_q;
    wait_d     = wait_q;
    dm_addr_d  = dm_addr_q;
    dm_wdata_d = dm_wdata_q;
    dm_we_d    = 1'b0;
    dm_re_d    = 1'b0;
    load_rd_d  = load_rd_q;
    done_d     = 1'b0;
    dbg_d      = rd_c;
    wb_en      = 1'b0;
    wb_addr    = dec.rd;
    wb_data    = rd_a;
    wp_en      = 1'b0;
    wp_idx     = dec.pair;
    wp_data    = ptr_next;
    unique case (state_q)
      S_EXEC: begin
        pc_d   = pc_q + PC_STEP;
        done_d = 1'b1;
        unique case (dec.cls)
          C_SKIP: begin
            // skip length follows the size of the word skipped
            if (io_bit == dec.pol) begin
              done_d  = 1'b0;
              state_d = S_WAIT;
              if (cbim_two_word(IW_NEXT_I)) begin
                pc_d   = pc_q + PC_SKIP2;
                wait_d = WAIT_SKIP2;
              end else begin
                pc_d   = pc_q + PC_SKIP1;
                wait_d = WAIT_SKIP1;
              end
            end
          end
          C_BRANCH: begin
            if (taken) begin
              pc_d    = pc_q + koff_ext + PC_STEP;
              done_d  = 1'b0;
              state_d = S_WAIT;
              wait_d  = WAIT_TAKEN;
            end
          end
          C_REGMOVE: begin
            wb_en = 1'b1;
          end
          C_PAIRCOPY: begin
            wp_en   = 1'b1;
            wp_idx  = dec.rd[4:1];
            wp_data = {rd_b, rd_a};
          end
          C_LOADIMM: begin
            wb_en   = 1'b1;
            wb_data = dec.imm;
          end
          C_LOAD, C_STORE: begin
            // address and strobe go out registered next cycle
            done_d     = 1'b0;
            state_d    = S_MEM;
            dm_addr_d  = mem_addr;
            dm_re_d    = (dec.cls == C_LOAD);
            dm_we_d    = (dec.cls == C_STORE);
            dm_wdata_d = rd_a;
            load_rd_d  = dec.rd;
            // pointer updated now; data moves next cycle
            wp_en = (dec.amode == A_INC) || (dec.amode == A_DEC);
            if (dec.amode == A_DIRECT) begin
              pc_d = pc_q + PC_SKIP1;
            end
          end
          C_OTHER: begin
            done_d = 1'b1;
          end
        endcase
      end
      S_MEM: begin
        // second cycle: load result lands in its register
        wb_en   = dm_re_q;
        wb_addr = load_rd_q;
        wb_data = DM_RDATA_I;
        state_d = S_EXEC;
        done_d  = 1'b1;
      end
      S_WAIT: begin
        // dead cycles after a taken branch or a skip
        wait_d = wait_q - WAIT_TAKEN;
        if (wait_q == WAIT_TAKEN) begin
          state_d = S_EXEC;
          done_d  = 1'b1;
        end
      end
    endcase
  end

  // ****************************************************************
  // execution sequencer: registers
  // ****************************************************************
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_q    <= S_EXEC;
      pc_q       <= PC_RESET;
      wait_q     <= 2'h0;
      dm_addr_q  <= 16'h0000;
      dm_wdata_q <= 8'h00;
      dm_we_q    <= 1'b0;
      dm_re_q    <= 1'b0;
      load_rd_q  <= 5'h00;
      done_q     <= 1'b0;
      dbg_q      <= 8'h00;
    end else begin
      state_q    <= state_d;
      pc_q       <= pc_d;
      wait_q     <= wait_d;
      dm_addr_q  <= dm_addr_d;
      dm_wdata_q <= dm_wdata_d;
      dm_we_q    <= dm_we_d;
      dm_re_q    <= dm_re_d;
      load_rd_q  <= load_rd_d;
      done_q     <= done_d;
      dbg_q      <= dbg_d;
    end
  end

  // ****************************************************************
  // outputs, all straight from flops
  // ****************************************************************
  assign PC_O       = pc_q;
  assign DM_ADDR_O  = dm_addr_q;
  assign DM_WDATA_O = dm_wdata_q;
  assign DM_WE_O    = dm_we_q;
  assign DM_RE_O    = dm_re_q;
  assign DONE_O     = done_q;
  assign REG_DATA_O = dbg_q;

endmodule
`default_nettype wire

// ---- design/cbim_pkg.sv ----
// Purpose: shared constants, types and decode helpers for the branch,
//          skip and data-transfer execution block
// Assumes: 16-bit instruction words, 8-bit data, 32 working registers
// Notes:   opcode patterns are compared as (word & mask) == pattern
`default_nettype none
package cbim_pkg;

  // ****************************************************************
  // widths and reset values
  // ****************************************************************
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] PC_STEP  = 16'h0001;
  localparam logic [15:0] PC_SKIP1 = 16'h0002;
  localparam logic [15:0] PC_SKIP2 = 16'h0003;
  localparam logic [4:0]  IMM_BASE = 5'h10;

  // ****************************************************************
  // opcode masks and patterns
  // ****************************************************************
  localparam logic [15:0] M_SKIPIO  = 16'hFD00;
  localparam logic [15:0] P_SKIPIO  = 16'h9900;
  localparam logic [15:0] M_BRB     = 16'hF800;
  localparam logic [15:0] P_BRB     = 16'hF000;
  localparam logic [15:0] M_REGMOVE  = 16'hFC00;
  localparam logic [15:0] P_REGMOVE  = 16'h2C00;
  localparam logic [15:0] M_PAIRCOPY = 16'hFF00;
  localparam logic [15:0] P_PAIRCOPY = 16'h0100;
  localparam logic [15:0] M_LOADIMM  = 16'hF000;
  localparam logic [15:0] P_LOADIMM  = 16'hE000;
  localparam logic [15:0] M_LDST    = 16'hFC00;
  localparam logic [15:0] P_LDST    = 16'h9000;
  localparam logic [15:0] M_DISP    = 16'hD000;
  localparam logic [15:0] P_DISP    = 16'h8000;
  localparam logic [15:0] M_DIRECT  = 16'hFC0F;
  localparam logic [15:0] P_DIRECT  = 16'h9000;
  localparam logic [15:0] M_JMPCALL = 16'hFE0C;
  localparam logic [15:0] P_JMPCALL = 16'h940C;

  // low nibble of direct and indirect load/store words
  localparam logic [3:0] N_DIRECT = 4'h0;
  localparam logic [3:0] N_Z_INC  = 4'h1;
  localparam logic [3:0] N_Z_DEC  = 4'h2;
  localparam logic [3:0] N_Y_INC  = 4'h9;
  localparam logic [3:0] N_Y_DEC  = 4'hA;
  localparam logic [3:0] N_X      = 4'hC;
  localparam logic [3:0] N_X_INC  = 4'hD;
  localparam logic [3:0] N_X_DEC  = 4'hE;

  // pointer pair indices (register number / 2)
  localparam logic [3:0] PAIR_X = 4'hD;
  localparam logic [3:0] PAIR_Y = 4'hE;
  localparam logic [3:0] PAIR_Z = 4'hF;

  // ****************************************************************
  // status register bit positions
  // ****************************************************************
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  // ****************************************************************
  // timing: extra dead cycles after the first execute cycle
  // ****************************************************************
  localparam logic [1:0] WAIT_TAKEN = 2'h1;
  localparam logic [1:0] WAIT_SKIP1 = 2'h1;
  localparam logic [1:0] WAIT_SKIP2 = 2'h2;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {
    C_OTHER, C_SKIP, C_BRANCH, C_REGMOVE, C_PAIRCOPY, C_LOADIMM, C_LOAD,
    C_STORE
  } cbim_cls_t;

  typedef enum logic [2:0] {
    A_PLAIN, A_INC, A_DEC, A_DISP, A_DIRECT
  } cbim_amode_t;

  // true for words that carry a second address word
  function automatic logic cbim_two_word(input logic [15:0] w);
    return ((w & M_DIRECT) == P_DIRECT) || ((w & M_JMPCALL) == P_JMPCALL);
  endfunction

endpackage
`default_nettype wire

// ---- design/cbim_dec_if.sv ----
// Purpose: carries an instruction word to the decoder and its fields back
// Assumes: purely combinational contents
// Notes:   core drives iw, decoder drives everything else
`timescale 1ns/1ps
`default_nettype none
interface cbim_dec_if;
  import cbim_pkg::*;

  logic [15:0] iw;
  cbim_cls_t   cls;
  cbim_amode_t amode;
  logic [3:0]  pair;
  logic [4:0]  rd;
  logic [4:0]  rr;
  logic        pol;
  logic [2:0]  sbit;
  logic [6:0]  koff;
  logic [7:0]  imm;
  logic [5:0]  disp;

  // decoder side
  modport dec_mp (input iw, output cls, amode, pair, rd, rr, pol, sbit,
                  koff, imm, disp);
  // execution side
  modport core_mp (output iw, input cls, amode, pair, rd, rr, pol, sbit,
                   koff, imm, disp);
endinterface
`default_nettype wire

// ---- design/cbim_decode.sv ----
// Purpose: classifies one instruction word and extracts its operands
// Assumes: word is stable for the whole cycle
// Notes:   anything outside this block's classes reports C_OTHER
`timescale 1ns/1ps
`default_nettype none
module cbim_decode (
  // decoded fields
  cbim_dec_if.dec_mp d
);
  import cbim_pkg::*;

  // ****************************************************************
  // field extraction and class selection
  // ****************************************************************
  always_comb begin
    d.cls   = C_OTHER;
    d.amode = A_PLAIN;
    d.pair  = PAIR_Z;
    d.rd    = d.iw[8:4];
    d.rr    = {d.iw[9], d.iw[3:0]};
    d.pol   = d.iw[9];
    d.sbit  = d.iw[2:0];
    d.koff  = d.iw[9:3];
    d.imm   = {d.iw[11:8], d.iw[3:0]};
    d.disp  = {d.iw[13], d.iw[11:10], d.iw[2:0]};
    if ((d.iw & M_SKIPIO) == P_SKIPIO) begin
      d.cls = C_SKIP;
    end else if ((d.iw & M_BRB) == P_BRB) begin
      d.cls = C_BRANCH;
      d.pol = d.iw[10]; // set: clear variant
    end else if ((d.iw & M_REGMOVE) == P_REGMOVE) begin
      d.cls = C_REGMOVE;
    end else if ((d.iw & M_PAIRCOPY) == P_PAIRCOPY) begin
      d.cls = C_PAIRCOPY;
      d.rd  = {d.iw[7:4], 1'b0};
      d.rr  = {d.iw[3:0], 1'b0};
    end else if ((d.iw & M_LOADIMM) == P_LOADIMM) begin
      d.cls = C_LOADIMM;
      d.rd  = IMM_BASE | {1'b0, d.iw[7:4]};
    end else if ((d.iw & M_LDST) == P_LDST) begin
      d.cls = d.iw[9] ? C_STORE : C_LOAD;
      unique case (d.iw[3:0])
        N_DIRECT: d.amode = A_DIRECT;
        N_Z_INC: d.amode = A_INC;
        N_Z_DEC: d.amode = A_DEC;
        N_Y_INC: begin
          d.amode = A_INC;
          d.pair  = PAIR_Y;
        end
        N_Y_DEC: begin
          d.amode = A_DEC;
          d.pair  = PAIR_Y;
        end
        N_X: d.pair = PAIR_X;
        N_X_INC: begin
          d.amode = A_INC;
          d.pair  = PAIR_X;
        end
        N_X_DEC: begin
          d.amode = A_DEC;
          d.pair  = PAIR_X;
        end
        default: d.cls = C_OTHER; // other opcodes of this group
      endcase
    end else if ((d.iw & M_DISP) == P_DISP) begin
      d.cls   = d.iw[9] ? C_STORE : C_LOAD;
      d.amode = A_DISP;
      d.pair  = d.iw[3] ? PAIR_Y : PAIR_Z;
    end
  end

endmodule
`default_nettype wire

// ---- design/cbim_regfile.sv ----
// Purpose: 32 x 8 working registers with byte and pair write ports
// Assumes: at most one write port active per cycle
// Notes:   all reads are combinational; contents are not reset
`timescale 1ns/1ps
`default_nettype none
module cbim_regfile (
  // clock
  input  wire logic        clk_i,
  // byte read ports
  input  wire logic [4:0]  ra_addr_i,
  output logic      [7:0]  ra_data_o,
  input  wire logic [4:0]  rb_addr_i,
  output logic      [7:0]  rb_data_o,
  input  wire logic [4:0]  rc_addr_i,
  output logic      [7:0]  rc_data_o,
  // pair read port
  input  wire logic [3:0]  rp_idx_i,
  output logic      [15:0] rp_data_o,
  // byte write port
  input  wire logic        wb_en_i,
  input  wire logic [4:0]  wb_addr_i,
  input  wire logic [7:0]  wb_data_i,
  // pair write port
  input  wire logic        wp_en_i,
  input  wire logic [3:0]  wp_idx_i,
  input  wire logic [15:0] wp_data_i
);

  logic [7:0] mem [32];

  // ****************************************************************
  // reads
  // ****************************************************************
  assign ra_data_o = mem[ra_addr_i];
  assign rb_data_o = mem[rb_addr_i];
  assign rc_data_o = mem[rc_addr_i];
  assign rp_data_o = {mem[{rp_idx_i, 1'b1}], mem[{rp_idx_i, 1'b0}]};

  // ****************************************************************
  // writes, low byte at the even register
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (wb_en_i) begin
      mem[wb_addr_i] <= wb_data_i;
    end
    if (wp_en_i) begin
      mem[{wp_idx_i, 1'b0}] <= wp_data_i[7:0];
      mem[{wp_idx_i, 1'b1}] <= wp_data_i[15:8];
    end
  end

endmodule
`default_nettype wire

// ---- verif/cbim_core_properties.sv ----
// Purpose: timing and flow checks on the cbim_core ports
// Assumes: one clock; a cycle with DONE_O high starts an instruction
// Notes:   attached to every cbim_core instance by the bind below
`timescale 1ns/1ps
`default_nettype none
module cbim_core_properties (
  // clock and reset
  input wire logic        CLK_I,
  input wire logic        RST_I,
  // watched ports
  input wire logic [15:0] PC_O,
  input wire logic [15:0] IW_I,
  input wire logic [15:0] IW_NEXT_I,
  input wire logic [7:0]  FLAGS_I,
  input wire logic [7:0]  IO_RDATA_I,
  input wire logic [15:0] DM_ADDR_O,
  input wire logic [7:0]  DM_WDATA_O,
  input wire logic        DM_WE_O,
  input wire logic        DM_RE_O,
  input wire logic        DONE_O
);
  import cbim_pkg::*;
  // ********
  // helpers and properties
  // ********
  logic        started_q, started_d, flag, hit, one_w;
  logic [15:0] tgt;
  // branch condition, skip hit and relative target of the current word
  always_comb begin
    started_d = started_q | DONE_O;
    flag = IW_I[2:0] == FLAG_S ? FLAGS_I[FLAG_N] ^ FLAGS_I[FLAG_V]
                               : FLAGS_I[IW_I[2:0]];
    tgt = PC_O + {{9{IW_I[9]}}, IW_I[9:3]} + PC_STEP;
    hit = (IW_I & M_SKIPIO) == P_SKIPIO && IO_RDATA_I[IW_I[2:0]] == IW_I[9];
    one_w = (IW_NEXT_I & M_DIRECT) != P_DIRECT
          && (IW_NEXT_I & M_JMPCALL) != P_JMPCALL;
  end
  // first boundary after reset; earlier cycles carry no DONE_O history
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      started_q <= 1'b0;
    end else begin
      started_q <= started_d;
    end
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  sequence s_br; DONE_O && (IW_I & M_BRB) == P_BRB; endsequence
  sequence s_end2; !DONE_O ##1 DONE_O; endsequence
  property p_taken;
    s_br ##0 (flag ^ IW_I[10]) |=> PC_O == $past(tgt) ##0 s_end2;
  endproperty
  property p_fall;
    s_br ##0 !(flag ^ IW_I[10]) |=> PC_O == $past(PC_O) + PC_STEP && DONE_O;
  endproperty
  property p_skip;
    DONE_O && hit && one_w |=> PC_O == $past(PC_O) + PC_SKIP1 ##0 s_end2;
  endproperty
  property p_load; DM_RE_O |-> s_end2 ##0 !DM_RE_O; endproperty
  property p_store;
    DM_WE_O |-> s_end2 ##0 !DM_WE_O && $stable(DM_ADDR_O)
      && $stable(DM_WDATA_O);
  endproperty
  property p_hold; started_q && !DONE_O |=> $stable(PC_O); endproperty
  property p_bound; started_q |-> ##[0:2] DONE_O; endproperty
  property p_imm;
    DONE_O && (IW_I & M_LOADIMM) == P_LOADIMM |=> DONE_O && !DM_RE_O
      && !DM_WE_O
      && PC_O == $past(PC_O) + PC_STEP;
  endproperty
  a_taken: assert property (p_taken)
    else $error("taken branch target or timing wrong");
  a_fall: assert property (p_fall)
    else $error("untaken branch not one cycle");
  a_skip: assert property (p_skip)
    else $error("skip over one word wrong");
  a_load: assert property (p_load)
    else $error("load strobe timing wrong");
  a_store: assert property (p_store)
    else $error("store strobe timing wrong");
  a_hold: assert property (p_hold)
    else $error("program counter moved in a dead cycle");
  a_bound: assert property (p_bound)
    else $error("instruction longer than three cycles");
  a_imm: assert property (p_imm)
    else $error("immediate load not single cycle");
endmodule
bind cbim_core cbim_core_properties u_cbim_core_properties (
  .CLK_I(CLK_I), .RST_I(RST_I), .PC_O(PC_O), .IW_I(IW_I),
  .IW_NEXT_I(IW_NEXT_I), .FLAGS_I(FLAGS_I), .IO_RDATA_I(IO_RDATA_I),
  .DM_ADDR_O(DM_ADDR_O), .DM_WDATA_O(DM_WDATA_O), .DM_WE_O(DM_WE_O),
  .DM_RE_O(DM_RE_O), .DONE_O(DONE_O));
`default_nettype wire

// ---- verif/cbim_core_tb.sv ----
// Purpose: self-checking bench for cbim_core
// Assumes: bench models program and data memory around the core
// Notes:   expectations come from a bench mirror of the registers
`timescale 1ns/1ps
`default_nettype none
module cbim_core_tb;
  import cbim_pkg::*;
  // ********
  // stimulus, memories and checks
  // ********
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        we, re, done, wr, pol, tk;
  logic [15:0] pc, addr, p, np, ea, k16, w, wa_c;
  logic [15:0] iw = 16'h0000;
  logic [15:0] iw2 = 16'h0000;
  logic [7:0]  flags = 8'h00, io = 8'h00, rdata = 8'h00;
  logic [7:0]  flags_v = 8'h00, io_v = 8'h00;
  logic [7:0]  wdata, rdo, v, wd_c;
  logic [4:0]  sel = 5'h00, sel_v = 5'h00, d, lo;
  logic [6:0]  k;
  logic [5:0]  q;
  logic [3:0]  nb;
  logic [2:0]  b;
  logic [15:0] nxt [6] = '{16'h0000, 16'h9001, 16'h9010, 16'h9210,
                           16'h940C, 16'h940D};
  logic [3:0]  nibs [10] = '{4'hC, 4'hD, 4'hE, 4'h9, 4'hA, 4'h1, 4'h2,
                             4'h0, 4'h0, 4'h0};
  logic [15:0] prog [65536];
  logic [7:0]  dmem [65536];
  logic [7:0]  regv [32];
  int          seed = 94727;
  int          miscompares = 0;
  int          n_tests = 0;
  int          m, c;

  cbim_core u_cbim_core (
    .CLK_I(clk), .RST_I(rst), .PC_O(pc), .IW_I(iw), .IW_NEXT_I(iw2),
    .FLAGS_I(flags), .IO_RDATA_I(io), .DM_ADDR_O(addr), .DM_WDATA_O(wdata),
    .DM_WE_O(we), .DM_RE_O(re), .DM_RDATA_I(rdata), .DONE_O(done),
    .REG_SEL_I(sel), .REG_DATA_O(rdo));

  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end
  // memories answer on the falling edge; idle read data keeps toggling
  always @(negedge clk) begin
    iw <= prog[pc];
    iw2 <= prog[pc + 16'h0001];
    flags <= flags_v;
    io <= io_v;
    sel <= sel_v;
    rdata <= re ? dmem[addr] : ~rdata;
  end
  // capture each store where its strobe is sampled
  always @(posedge clk) begin
    if (we === 1'b1) begin
      wa_c <= addr;
      wd_c <= wdata;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic hang();
    miscompares++;
    results();
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  // puts two words at the current PC and PC+1 and times the first up to the next boundary
  task automatic run(input logic [15:0] w0, w1, dpc, input int cyc);
    logic [15:0] pc0;
    int          n;
    for (n = 0; done !== 1'b1; n++) begin
      if (n > 8) hang();
      tick();
    end
    pc0 = pc;
    prog[pc0] = w0;
    prog[pc0 + 16'h0001] = w1;
    n = 0;
    do begin
      tick();
      n++;
      if (n > 8) hang();
    end while (done !== 1'b1);
    prog[pc0] = 16'h0000;
    prog[pc0 + 16'h0001] = 16'h0000;
    chk(pc, pc0 + dpc);
    chk(16'(n), 16'(cyc));
  endtask
  task automatic put_imm(input logic [4:0] r, input logic [7:0] val);
    run({4'hE, val[7:4], r[3:0], val[3:0]}, 16'h0000, 16'h0001, 1);
    regv[r] = val;
  endtask
  task automatic chkreg(input logic [4:0] r);
    sel_v = r;
    tick();
    chk({8'h00, rdo}, {8'h00, regv[r]});
  endtask

  // main sequence
  initial begin
    foreach (prog[i]) prog[i] = 16'h0000;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    for (int r = 16; r < 32; r++) begin
      put_imm(5'(r), 8'($random(seed)));
      chkreg(5'(r));
    end
    $display("test immediates done");
    for (int i = 0; i < 8; i++) begin
      d = 5'(16 + i);
      lo = 5'(16 + ($random(seed) & 15));
      run({6'h0B, lo[4], d, lo[3:0]}, 16'h0000, 16'h0001, 1);
      regv[d] = regv[lo];
      chkreg(d);
      m = 8 + (i & 3);
      c = 8 + ($random(seed) & 7);
      run({8'h01, 4'(m), 4'(c)}, 16'h0000, 16'h0001, 1);
      regv[2 * m] = regv[2 * c];
      regv[2 * m + 1] = regv[2 * c + 1];
      chkreg(5'(2 * m + 1));
    end
    $display("test moves done");
    for (int i = 0; i < 48; i++) begin
      flags_v = 8'($random(seed));
      pol = i[3];
      b = 3'(i);
      k = i < 8 ? 7'h40 : i < 16 ? 7'h3F : i < 24 ? 7'h7F
        : 7'($random(seed));
      tk = pol ^ (b == FLAG_S ? flags_v[FLAG_N] ^ flags_v[FLAG_V]
                              : flags_v[b]);
      run({5'h1E, pol, k, b}, 16'h0000,
          tk ? {{9{k[6]}}, k} + 16'h0001 : 16'h0001,
          tk ? 2 : 1);
    end
    $display("test branches done");
    for (int i = 0; i < 24; i++) begin
      io_v = 8'($random(seed));
      b = 3'($random(seed));
      pol = i >= 12;
      c = io_v[b] != pol ? 1 : i % 6 > 1 ? 3 : 2;
      w = {6'h26, pol, 1'b1, 5'($random(seed)), b};
      run(w, nxt[i % 6], 16'(c), c);
    end
    $display("test skips done");
    for (int j = 0; j < 60; j++) begin
      m = (j / 2) % 10;
      wr = j[0];
      p = j < 20 ? 16'h0000 : j < 40 ? 16'hFFFF : 16'($random(seed));
      q = 6'($random(seed));
      k16 = 16'($random(seed));
      d = 5'(16 + (m & 7));
      lo = m < 3 ? 5'h1A : (m < 5 || m == 7) ? 5'h1C : 5'h1E;
      nb = nibs[m];
      np = p + 16'(nb[0]) - 16'(nb[1]);
      ea = m == 9 ? k16 : m > 6 ? p + 16'(q) : nb[1] ? np : p;
      w = (m == 7 || m == 8)
        ? {2'h2, q[5], 1'b0, q[4:3], wr, d, 1'(m == 7), q[2:0]}
        : {6'h24, wr, d, nb};
      put_imm(lo, p[7:0]);
      put_imm(lo + 5'h01, p[15:8]);
      v = 8'($random(seed));
      dmem[ea] = v;
      run(w, k16, m == 9 ? 16'h0002 : 16'h0001, 2);
      if (wr) begin
        chk(wa_c, ea);
        chk({8'h00, wd_c}, {8'h00, regv[d]});
      end else begin
        regv[d] = v;
        chkreg(d);
      end
      regv[lo] = np[7:0];
      regv[lo + 5'h01] = np[15:8];
      chkreg(lo);
      chkreg(lo + 5'h01);
    end
    $display("test data transfers done");
    results();
  end
endmodule
`default_nettype wire
